// [rtl/mcs_regs.vh]
// register offsets, field positions and constants of the monitoring circuit supervisor
`ifndef MCS_REGS_VH
`define MCS_REGS_VH
// byte offsets on the register bus
`define MCS_OFF_GLOBAL   6'h00
`define MCS_OFF_STATUS   6'h04
`define MCS_OFF_CH0      6'h10
`define MCS_OFF_CH1      6'h14
`define MCS_OFF_CH2      6'h18
`define MCS_OFF_CH3      6'h1c
// global register fields
`define MCS_GL_SPD_LSB   0
`define MCS_GL_SPD_MSB   12
`define MCS_GL_IOPROF    16
`define MCS_SPD_RST      13'h0000
`define MCS_SPD_MAX      13'h1766
// status register fields
`define MCS_ST_WARN_LSB  0
`define MCS_ST_ERR_LSB   4
`define MCS_ST_EVT_LSB   8
// channel register fields
`define MCS_CH_KIND_LSB  0
`define MCS_CH_KIND_MSB  2
`define MCS_CH_IDX_LSB   4
`define MCS_CH_IDX_MSB   7
`define MCS_CH_LOW       8
`define MCS_CH_QUAL_LSB  9
`define MCS_CH_QUAL_MSB  10
`define MCS_CH_RESP_LSB  12
`define MCS_CH_RESP_MSB  14
`define MCS_CH_DLY_LSB   16
`define MCS_CH_DLY_MSB   24
`define MCS_CH_MASK      32'h01ff77f7
`define MCS_CH_QD_MASK   32'h01ff0600
`define MCS_CH_RST       32'h00001000
`define MCS_DLY_MAX      9'h12c
// source kinds
`define MCS_KIND_NONE    3'h0
`define MCS_KIND_DI      3'h1
`define MCS_KIND_CW0     3'h2
`define MCS_KIND_CW4     3'h6
// qualifier codes
`define MCS_Q_ALWAYS     2'h0
`define MCS_Q_RDY_RUN    2'h1
`define MCS_Q_RUN        2'h2
// response codes
`define MCS_R_IGNORE     3'h0
`define MCS_R_FREEWHEEL  3'h1
`define MCS_R_PER_STT    3'h2
`define MCS_R_FALLBACK   3'h3
`define MCS_R_MAINTAIN   3'h4
`define MCS_R_RAMP       3'h5
`define MCS_R_FAST       3'h6
`define MCS_R_DC         3'h7
// time base
`define MCS_CLK_HZ       40000000
`define MCS_TICK_S       1
`endif

// [rtl/mcs_top.v]
// monitoring circuit supervisor: four channels behind an avalon-mm slave
`default_nettype none
`include "mcs_regs.vh"
module mcs_top #(
    parameter integer TICK_CYCLES = `MCS_CLK_HZ * `MCS_TICK_S, // cycles per second tick
    parameter integer TICK_W      = 26                         // width of tick prescaler
) (
    input  wire        mclk,
    input  wire        rstn,
    input  wire [5:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    input  wire [15:0] digital_in,
    input  wire [15:0] cw_terminal,
    input  wire [15:0] cw_modbus,
    input  wire [15:0] cw_fieldbus,
    input  wire [15:0] cw_com_module,
    input  wire [15:0] cw_ethernet,
    input  wire        high_power_variant,
    input  wire        ext_io_fitted,
    input  wire        ethernet_fitted,
    input  wire        drive_ready,
    input  wire        drive_running,
    input  wire        run_command,
    output reg  [3:0]  supervision_warning_flag,
    output reg  [3:0]  supervision_error_flag,
    output reg         stop_request,
    output reg  [2:0]  stop_mode,
    output reg         fallback_active,
    output reg         speed_hold,
    output reg  [12:0] fallback_speed_out
);

    // bus handshake: one wait cycle, then the answer
    reg          ack_q;                   // second cycle of an access
    reg  [31:0]  cfg_q [0:3];             // per channel configuration words
    reg  [12:0]  fallback_speed_setting_q; // fallback speed, 0.1 hz units
    reg          control_mode_select_q;   // high selects the io profile
    reg  [8:0]   cnt_q [0:3];             // per channel delay counters, seconds
    reg  [TICK_W-1:0] tick_cnt_q;         // prescaler for the one second tick
    reg          tick_q;                  // one cycle pulse each second
    reg  [3:0]   evt_act;                 // qualified event per channel
    reg  [3:0]   expired;                 // delay elapsed while active
    reg  [3:0]   fb_sel;                  // channel selects fallback response
    integer      i;                       // channel index of the event logic only
    integer      ic;                      // channel index of the delay counters
    integer      iw;                      // channel index of the configuration reset
    reg  [3:0]   warn_d;                  // next warning flags
    reg  [3:0]   err_d;                   // next error flags
    reg          stop_d;                  // next stop request
    reg  [2:0]   mode_d;                  // next stop type
    reg          fb_d;                    // next fallback command
    reg          hold_d;                  // next speed hold command

    wire acc    = avs_read | avs_write;
    wire wr_en  = avs_write & ack_q;
    wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                           {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire any_fb = |fb_sel;

    assign avs_waitrequest = acc & ~ack_q;

    // whether a source selection is offered on this build and profile
    function sel_valid;
        input [2:0] kind;
        input [3:0] idx;
        input       low;
        input       io_prof;
        input       hp;
        input       ext;
        input       eth;
        begin
            if (kind == `MCS_KIND_DI) begin
                if (idx == 4'h7)
                    sel_valid = hp;
                else if (idx == 4'h8 || idx == 4'h9)
                    sel_valid = 1'b0;
                else if (idx >= 4'ha)
                    sel_valid = ext;
                else
                    sel_valid = 1'b1;
            end else if (kind >= `MCS_KIND_CW0 && kind <= `MCS_KIND_CW4) begin
                // low level is a property of physical inputs only
                if (low)
                    sel_valid = 1'b0;
                else if (kind == `MCS_KIND_CW4 && !eth)
                    sel_valid = 1'b0;
                else if (kind != `MCS_KIND_CW0 && idx == 4'h0)
                    sel_valid = 1'b0;
                else if (idx <= 4'ha)
                    sel_valid = io_prof;
                else
                    sel_valid = 1'b1;
            end else begin
                sel_valid = 1'b0;
            end
        end
    endfunction

    // merge a channel write; qualifier and delay only stick on an assigned source
    function [31:0] cfg_merge;
        input [31:0] old;
        input [31:0] wd;
        input [31:0] bm;
        reg   [31:0] nv;
        begin
            nv = ((old & ~bm) | (wd & bm)) & `MCS_CH_MASK;
            if (nv[`MCS_CH_KIND_MSB:`MCS_CH_KIND_LSB] == `MCS_KIND_NONE)
                nv = (nv & ~`MCS_CH_QD_MASK);
            if (nv[`MCS_CH_DLY_MSB:`MCS_CH_DLY_LSB] > `MCS_DLY_MAX)
                nv[`MCS_CH_DLY_MSB:`MCS_CH_DLY_LSB] = `MCS_DLY_MAX;
            if (nv[`MCS_CH_QUAL_MSB:`MCS_CH_QUAL_LSB] == 2'h3)
                nv[`MCS_CH_QUAL_MSB:`MCS_CH_QUAL_LSB] = `MCS_Q_ALWAYS;
            cfg_merge = nv;
        end
    endfunction

    // event detection and qualification for all channels
    always @* begin : evt_blk
        reg [2:0]  kind;
        reg [3:0]  idx;
        reg        raw;
        reg        qok;
        reg [15:0] word;
        kind = 3'h0;
        idx  = 4'h0;
        raw  = 1'b0;
        qok  = 1'b0;
        word = 16'h0000;
        for (i = 0; i < 4; i = i + 1) begin
            kind = cfg_q[i][`MCS_CH_KIND_MSB:`MCS_CH_KIND_LSB];
            idx  = cfg_q[i][`MCS_CH_IDX_MSB:`MCS_CH_IDX_LSB];
            // pick the word the selection points into
            if (kind == `MCS_KIND_DI)
                word = digital_in;
            else if (kind == 3'h2)
                word = cw_terminal;
            else if (kind == 3'h3)
                word = cw_modbus;
            else if (kind == 3'h4)
                word = cw_fieldbus;
            else if (kind == 3'h5)
                word = cw_com_module;
            else
                word = cw_ethernet;
            if (cfg_q[i][`MCS_CH_LOW])
                raw = ~word[idx];
            else
                raw = word[idx];
            // unoffered selections behave as not assigned
            if (!sel_valid(kind, idx, cfg_q[i][`MCS_CH_LOW], control_mode_select_q,
                           high_power_variant, ext_io_fitted, ethernet_fitted))
                raw = 1'b0;
            case (cfg_q[i][`MCS_CH_QUAL_MSB:`MCS_CH_QUAL_LSB])
                `MCS_Q_RDY_RUN: qok = drive_ready | drive_running;
                `MCS_Q_RUN:     qok = drive_running;
                default:        qok = 1'b1;
            endcase
            evt_act[i] = raw & qok;
            expired[i] = evt_act[i] & (cnt_q[i] >= cfg_q[i][`MCS_CH_DLY_MSB:`MCS_CH_DLY_LSB]);
            fb_sel[i]  = (cfg_q[i][`MCS_CH_RESP_MSB:`MCS_CH_RESP_LSB] == `MCS_R_FALLBACK);
        end
    end

    // one second time base; the delay resolution is one tick
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tick_cnt_q <= {TICK_W{1'b0}};
            tick_q     <= 1'b0;
        end else if (tick_cnt_q == TICK_CYCLES[TICK_W-1:0] - 1'b1) begin
            tick_cnt_q <= {TICK_W{1'b0}};
            tick_q     <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
            tick_q     <= 1'b0;
        end
    end

    // delay counters: first second may be short since the tick runs free
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            for (ic = 0; ic < 4; ic = ic + 1)
                cnt_q[ic] <= 9'h000;
        end else begin
            for (ic = 0; ic < 4; ic = ic + 1) begin
                if (!evt_act[ic])
                    cnt_q[ic] <= 9'h000;
                else if (tick_q && !expired[ic])
                    cnt_q[ic] <= cnt_q[ic] + 1'b1;
            end
        end
    end

    // register writes and the bus handshake
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ack_q                    <= 1'b0;
            fallback_speed_setting_q <= `MCS_SPD_RST;
            control_mode_select_q    <= 1'b0;
            for (iw = 0; iw < 4; iw = iw + 1)
                cfg_q[iw] <= `MCS_CH_RST;
        end else begin
            ack_q <= acc & ~ack_q;
            if (wr_en) begin
                if (avs_address == `MCS_OFF_GLOBAL) begin
                    // speed is writable only while a channel selects fallback
                    if (any_fb && avs_byteenable[0] && avs_byteenable[1]) begin
                        if (avs_writedata[`MCS_GL_SPD_MSB:`MCS_GL_SPD_LSB] > `MCS_SPD_MAX)
                            fallback_speed_setting_q <= `MCS_SPD_MAX;
                        else
                            fallback_speed_setting_q <=
                                avs_writedata[`MCS_GL_SPD_MSB:`MCS_GL_SPD_LSB];
                    end
                    if (avs_byteenable[2])
                        control_mode_select_q <= avs_writedata[`MCS_GL_IOPROF];
                end else if (avs_address == `MCS_OFF_CH0) begin
                    cfg_q[0] <= cfg_merge(cfg_q[0], avs_writedata, be_mask);
                end else if (avs_address == `MCS_OFF_CH1) begin
                    cfg_q[1] <= cfg_merge(cfg_q[1], avs_writedata, be_mask);
                end else if (avs_address == `MCS_OFF_CH2) begin
                    cfg_q[2] <= cfg_merge(cfg_q[2], avs_writedata, be_mask);
                end else if (avs_address == `MCS_OFF_CH3) begin
                    cfg_q[3] <= cfg_merge(cfg_q[3], avs_writedata, be_mask);
                end
            end
        end
    end

    // read data is captured in the wait cycle so it stands at the answering edge
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && !ack_q) begin
            if (avs_address == `MCS_OFF_GLOBAL)
                avs_readdata <= {15'h0000, control_mode_select_q, 3'h0,
                                 any_fb ? fallback_speed_setting_q : 13'h0000};
            else if (avs_address == `MCS_OFF_STATUS)
                avs_readdata <= {20'h00000, evt_act, supervision_error_flag,
                                 supervision_warning_flag};
            else if (avs_address == `MCS_OFF_CH0)
                avs_readdata <= cfg_q[0];
            else if (avs_address == `MCS_OFF_CH1)
                avs_readdata <= cfg_q[1];
            else if (avs_address == `MCS_OFF_CH2)
                avs_readdata <= cfg_q[2];
            else if (avs_address == `MCS_OFF_CH3)
                avs_readdata <= cfg_q[3];
            else
                avs_readdata <= 32'h00000000; // unmapped reads as zero
        end
    end

    // response decode: warnings follow the event, errors latch until cleared
    always @* begin : resp_comb
        reg [2:0] rsp;
        integer   ir;
        rsp    = 3'h0;
        ir     = 0;
        warn_d = 4'h0;
        err_d  = supervision_error_flag;
        stop_d = 1'b0;
        mode_d = 3'h0;
        fb_d   = 1'b0;
        hold_d = 1'b0;
        for (ir = 3; ir >= 0; ir = ir - 1) begin
            rsp = cfg_q[ir][`MCS_CH_RESP_MSB:`MCS_CH_RESP_LSB];
            warn_d[ir] = expired[ir] &&
                (rsp == `MCS_R_IGNORE || rsp == `MCS_R_FALLBACK ||
                 rsp == `MCS_R_MAINTAIN);
            // a fresh error wins over a software clear in the same cycle
            if (expired[ir] && (rsp == `MCS_R_FREEWHEEL || rsp >= `MCS_R_RAMP))
                err_d[ir] = 1'b1;
            else if (wr_en && avs_address == `MCS_OFF_STATUS && avs_byteenable[0] &&
                     avs_writedata[`MCS_ST_ERR_LSB + ir])
                err_d[ir] = 1'b0;
            // lowest numbered stopping channel sets the stop type
            if (supervision_error_flag[ir] ||
                (expired[ir] && rsp == `MCS_R_PER_STT)) begin
                stop_d = 1'b1;
                mode_d = rsp;
            end
            if (expired[ir] && run_command && rsp == `MCS_R_FALLBACK)
                fb_d = 1'b1;
            if (expired[ir] && run_command && rsp == `MCS_R_MAINTAIN)
                hold_d = 1'b1;
        end
    end

    // response registers; a stop outranks fallback, fallback outranks hold
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            supervision_warning_flag <= 4'h0;
            supervision_error_flag   <= 4'h0;
            stop_request             <= 1'b0;
            stop_mode                <= 3'h0;
            fallback_active          <= 1'b0;
            speed_hold               <= 1'b0;
            fallback_speed_out       <= 13'h0000;
        end else begin
            supervision_warning_flag <= warn_d;
            supervision_error_flag   <= err_d;
            stop_request       <= stop_d;
            stop_mode          <= mode_d;
            fallback_active    <= fb_d & ~stop_d;
            speed_hold         <= hold_d & ~fb_d & ~stop_d;
            fallback_speed_out <= fallback_speed_setting_q;
        end
    end

endmodule // mcs_top
`default_nettype wire

// [sim/mcs_far_side.sv]
// far-side model: digital inputs and control words
`default_nettype none
module mcs_far_side (
    input  wire logic        mclk,
    output var  logic [15:0] digital_in,
    output var  logic [15:0] cw_terminal,
    output var  logic [15:0] cw_other
);
    timeunit 1ns;
    timeprecision 1ps;
    // other command sources stay silent; only terminal word is exercised
    initial begin
        digital_in  = 16'h0000;
        cw_terminal = 16'h0000;
        cw_other    = 16'h0000;
    end
    // new levels land just after an edge so the sampling edge never races
    task automatic put(input logic [15:0] di, input logic [15:0] cw);
        @(posedge mclk);
        digital_in  <= di;
        cw_terminal <= cw;
    endtask
endmodule // mcs_far_side
`default_nettype wire

// [sim/mcs_sva.sv]
// checker of the supervisor bus handshake and response outputs
`default_nettype none
module mcs_sva (
    input wire logic        mclk,
    input wire logic        rstn,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic        avs_waitrequest,
    input wire logic        run_command,
    input wire logic [3:0]  supervision_error_flag,
    input wire logic        stop_request,
    input wire logic [2:0]  stop_mode,
    input wire logic        fallback_active,
    input wire logic        speed_hold,
    input wire logic [12:0] fallback_speed_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    // a held request is answered after exactly one wait cycle
    property p_ack; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
    a_ack: assert property (p_ack)
        else $error("request not answered after one wait cycle");
    property p_idle; !avs_read && !avs_write |-> !avs_waitrequest; endproperty
    a_idle: assert property (p_idle)
        else $error("wait asserted with no request");
    // error flags only fall through a bus write
    property p_err_hold;
        !avs_write |=> (supervision_error_flag & $past(supervision_error_flag))
                       == $past(supervision_error_flag);
    endproperty
    a_err_hold: assert property (p_err_hold)
        else $error("error flag dropped without a clear");
    property p_err_stop; |supervision_error_flag |=> stop_request; endproperty
    a_err_stop: assert property (p_err_stop)
        else $error("error flag without stop request");
    property p_stop_mode; stop_request |-> stop_mode inside {3'h1, 3'h2, 3'h5, 3'h6, 3'h7}; endproperty
    a_stop_mode: assert property (p_stop_mode)
        else $error("stop with a non-stopping response code");
    property p_fb_run; fallback_active |-> $past(run_command) && !speed_hold; endproperty
    a_fb_run: assert property (p_fb_run)
        else $error("fallback without run command");
    property p_sh_run; speed_hold |-> $past(run_command) && !fallback_active; endproperty
    a_sh_run: assert property (p_sh_run)
        else $error("speed hold without run command");
    property p_spd_max; fallback_speed_out <= 13'h1766; endproperty
    a_spd_max: assert property (p_spd_max)
        else $error("fallback speed above range");
    c_stop: cover property (stop_request);
    c_fb: cover property (fallback_active);
    c_sh: cover property (speed_hold);
endmodule // mcs_sva
bind mcs_top mcs_sva i_sva (
    .mclk(mclk), .rstn(rstn), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .run_command(run_command),
    .supervision_error_flag(supervision_error_flag), .stop_request(stop_request),
    .stop_mode(stop_mode), .fallback_active(fallback_active), .speed_hold(speed_hold),
    .fallback_speed_out(fallback_speed_out)
);
`default_nettype wire

// [sim/mcs_top_tb.sv]
// self-checking testbench of the monitoring circuit supervisor
`default_nettype none
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin errors++; \
    $display("ERROR %s exp %0h got %0h", n, e, a); end end
module mcs_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk, rstn, avs_read, avs_write, avs_waitrequest;
    logic [5:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rdv;
    logic [3:0]  avs_byteenable, warn, err;
    logic        hp, ext, rdy, running, run, stop, fb, sh;
    logic [2:0]  stop_mode;
    logic [12:0] spd;
    logic [15:0] di, cwt, cwo;
    int          errors = 0;
    int          cmp_count = 0;
    mcs_far_side i_far (.mclk(mclk), .digital_in(di), .cw_terminal(cwt), .cw_other(cwo));
    mcs_top #(.TICK_CYCLES(10), .TICK_W(26)) i_dut (
        .mclk(mclk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .digital_in(di),
        .cw_terminal(cwt), .cw_modbus(cwo), .cw_fieldbus(cwo), .cw_com_module(cwo),
        .cw_ethernet(cwo), .high_power_variant(hp), .ext_io_fitted(ext), .ethernet_fitted(1'b0),
        .drive_ready(rdy), .drive_running(running), .run_command(run),
        .supervision_warning_flag(warn), .supervision_error_flag(err), .stop_request(stop),
        .stop_mode(stop_mode), .fallback_active(fb), .speed_hold(sh), .fallback_speed_out(spd));
    // 40 mhz clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // verdict and end of run
    task automatic wrap_up;
        $display("checks %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // channel word from its fields
    function automatic logic [31:0] cfg(input logic [2:0] k, input logic [3:0] ix, input logic lo,
                                        input logic [1:0] q, input logic [2:0] r, input logic [8:0] d);
        return {7'h00, d, 1'b0, r, 1'b0, q, lo, ix, 1'b0, k};
    endfunction
    // one avalon access; held until waitrequest is seen low, bounded
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int n;
        @(posedge mclk);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_read       <= ~w;
        avs_write      <= w;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (n == 50) begin
            errors++;
            wrap_up();
        end
        rdv = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d); bus(1'b1, a, d, 4'hf); endtask
    task automatic rd(input logic [5:0] a); bus(1'b0, a, 32'h0, 4'hf); endtask
    task automatic wt(input int c); repeat (c) @(negedge mclk); endtask
    // drive state and fitted hardware levels
    task automatic lv(input logic r, input logic g, input logic c, input logic h, input logic e);
        @(posedge mclk);
        rdy <= r; running <= g; run <= c; hp <= h; ext <= e;
    endtask
    // reset values and an unmapped place
    task automatic t_defaults;
        for (int i = 0; i < 4; i++) begin
            rd(6'h10 + 6'(4 * i));
            `CHK("chan reset", 32'h00001000, rdv)
        end
        rd(6'h00); `CHK("speed reset", 32'h0, rdv)
        rd(6'h08); `CHK("unmapped", 32'h0, rdv)
    endtask
    // gating and clamping of settings
    task automatic t_gating;
        wr(6'h10, cfg(3'h0, 4'h0, 1'b0, 2'h2, 3'h1, 9'h005)); rd(6'h10);
        `CHK("unassigned qual/dly", 32'h00001000, rdv)
        wr(6'h00, 32'h00001766); rd(6'h00); `CHK("speed hidden", 32'h0, rdv)
        wr(6'h10, cfg(3'h1, 4'h0, 1'b0, 2'h0, 3'h3, 9'h190)); rd(6'h10);
        `CHK("delay clamp", cfg(3'h1, 4'h0, 1'b0, 2'h0, 3'h3, 9'h12c), rdv)
        wr(6'h00, 32'h00001770); rd(6'h00); `CHK("speed clamp", 32'h00001766, rdv)
    endtask
    // delay of two seconds, short pulses and drops clear the count
    task automatic t_delay;
        int n;
        wr(6'h10, cfg(3'h1, 4'h0, 1'b0, 2'h0, 3'h0, 9'h002));
        i_far.put(16'h0001, 16'h0); wt(8);
        `CHK("warn early", 1'b0, warn[0])
        for (n = 0; n < 30 && warn[0] !== 1'b1; n++) wt(1);
        `CHK("warn after delay", 1'b1, warn[0])
        `CHK("ignore no stop", 1'b0, stop)
        i_far.put(16'h0, 16'h0); wt(3); `CHK("warn drop", 1'b0, warn[0])
        i_far.put(16'h0001, 16'h0); wt(5); i_far.put(16'h0, 16'h0); wt(25);
        `CHK("short pulse", 1'b0, warn[0])
    endtask
    // low level input with freewheel error, sticky until cleared
    task automatic t_low;
        i_far.put(16'h0002, 16'h0);
        wr(6'h14, cfg(3'h1, 4'h1, 1'b1, 2'h0, 3'h1, 9'h000)); wt(4);
        `CHK("low idle", 4'h0, err)
        i_far.put(16'h0000, 16'h0); wt(4); `CHK("low err", 4'h2, err)
        `CHK("err stop", 1'b1, stop)
        `CHK("stop mode", 3'h1, stop_mode)
        i_far.put(16'h0002, 16'h0); wt(4); `CHK("err sticky", 4'h2, err)
        rd(6'h04); `CHK("status", 32'h00000020, rdv)
        wr(6'h04, 32'h00000020); wt(2); `CHK("err clear", 4'h0, err)
        `CHK("stop gone", 1'b0, stop)
        wr(6'h14, cfg(3'h1, 4'h1, 1'b1, 2'h0, 3'h2, 9'h000));
        i_far.put(16'h0000, 16'h0); wt(4); `CHK("per stt stop", 1'b1, stop)
        `CHK("per stt mode", 3'h2, stop_mode)
        `CHK("per stt no err", 4'h0, err)
        wr(6'h14, 32'h00001000);
    endtask
    // drive state qualification on a terminal control bit
    task automatic t_qual;
        wr(6'h18, cfg(3'h2, 4'hc, 1'b0, 2'h2, 3'h0, 9'h000));
        lv(1'b1, 1'b0, 1'b0, 1'b0, 1'b0); i_far.put(16'h0, 16'h1000); wt(4);
        `CHK("run qual off", 1'b0, warn[2])
        lv(1'b1, 1'b1, 1'b0, 1'b0, 1'b0); wt(4); `CHK("run qual on", 1'b1, warn[2])
        wr(6'h18, cfg(3'h2, 4'hc, 1'b0, 2'h1, 3'h0, 9'h000));
        lv(1'b0, 1'b0, 1'b0, 1'b0, 1'b0); wt(4); `CHK("rdy qual off", 1'b0, warn[2])
        lv(1'b1, 1'b0, 1'b0, 1'b0, 1'b0); wt(4); `CHK("rdy qual on", 1'b1, warn[2])
        wr(6'h18, 32'h00001000);
    endtask
    // selections that depend on profile and fitted hardware
    task automatic t_access;
        wr(6'h1c, cfg(3'h2, 4'h3, 1'b0, 2'h0, 3'h0, 9'h000));
        i_far.put(16'h0, 16'h0008); wt(4); `CHK("bit3 no prof", 1'b0, warn[3])
        bus(1'b1, 6'h00, 32'h00010000, 4'h4); wt(4); `CHK("bit3 prof", 1'b1, warn[3])
        wr(6'h1c, cfg(3'h1, 4'h7, 1'b0, 2'h0, 3'h0, 9'h000));
        i_far.put(16'h0080, 16'h0); wt(4); `CHK("in8 low power", 1'b0, warn[3])
        lv(1'b1, 1'b0, 1'b0, 1'b1, 1'b0); wt(4); `CHK("in8 high power", 1'b1, warn[3])
        wr(6'h1c, cfg(3'h1, 4'ha, 1'b0, 2'h0, 3'h0, 9'h000));
        i_far.put(16'h0400, 16'h0); wt(4); `CHK("in11 no module", 1'b0, warn[3])
        lv(1'b1, 1'b0, 1'b0, 1'b1, 1'b1); wt(4); `CHK("in11 module", 1'b1, warn[3])
        wr(6'h1c, 32'h00001000);
    endtask
    // fallback and maintained speed follow event and run command
    task automatic t_fallback;
        wr(6'h10, cfg(3'h1, 4'h0, 1'b0, 2'h0, 3'h3, 9'h000));
        wr(6'h00, 32'h00010100);
        i_far.put(16'h0001, 16'h0); lv(1'b1, 1'b1, 1'b1, 1'b1, 1'b1); wt(4);
        `CHK("fallback on", 1'b1, fb)
        `CHK("fallback speed", 13'h0100, spd)
        `CHK("fallback warn", 1'b1, warn[0])
        `CHK("fallback no stop", 1'b0, stop)
        lv(1'b1, 1'b1, 1'b0, 1'b1, 1'b1); wt(4); `CHK("fallback no run", 1'b0, fb)
        wr(6'h10, cfg(3'h1, 4'h0, 1'b0, 2'h0, 3'h4, 9'h000));
        lv(1'b1, 1'b1, 1'b1, 1'b1, 1'b1); wt(4); `CHK("hold on", 1'b1, sh)
        i_far.put(16'h0, 16'h0); wt(4); `CHK("hold off", 1'b0, sh)
    endtask
    // main sequence
    initial begin
        rstn = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = 6'h00;
        avs_writedata = 32'h0; avs_byteenable = 4'h0; hp = 1'b0; ext = 1'b0;
        rdy = 1'b0; running = 1'b0; run = 1'b0;
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        t_defaults; t_gating; t_delay; t_low; t_qual; t_access; t_fallback;
        wrap_up();
    end
endmodule // mcs_top_tb
`default_nettype wire
